// ---- src/irq_ctrl.sv ----
// The address map and the Wishbone slave port were chosen for this implementation.
`timescale 1ns/1ps
module irq_ctrl
    import irq_ctrl_pkg::*;
#(
    parameter logic [NUM_SRC-1:0][15:0] SRC_VECTOR = {
        16'h0150, 16'h0140, 16'h0130, 16'h0120, 16'h0110, 16'h0100,
        16'h00f0, 16'h00e0, 16'h00d0, 16'h00c0, 16'h00b0}
)
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic mc_tick,
    input wire logic instr_end,
    input wire logic instr_is_reti,
    input wire logic instr_wr_irq_regs,
    input wire logic reti_done,
    input wire logic timer0_overflow,
    input wire logic timer1_overflow,
    input wire logic ext_req0_n,
    input wire logic ext_req1_n,
    input wire logic [4:0] ext_edge,
    input wire logic serial0_flag,
    input wire logic serial1_flag,
    input wire logic watchdog_started_status,
    output logic lcall_req,
    output logic [15:0] lcall_vector,
    output logic lcall_busy,
    output logic timer0_run,
    output logic timer1_run
);

    // Whole state of the controller
    typedef struct packed {
        logic [7:0] en_a;          // Enable A incl. global bit
        logic [7:0] en_b;          // Enable B
        logic [7:0] en_c;          // Enable C
        logic [5:0] pri_lo;        // Priority low bits per group
        logic [5:0] pri_hi;        // Priority high bits per group
        logic [7:0] tev;           // Timer event control
        logic [4:0] xflags;        // Edge flags of requests 6..2
        logic ext0_prev;           // Last request 0 pin level
        logic ext1_prev;           // Last request 1 pin level
        logic [NUM_SRC-1:0] sample; // Per-machine-cycle sample
        logic [3:0] active;        // In-service level bits
        call_state_t state;        // Idle or forcing a call
        logic [2:0] call_cnt;      // Machine cycles left in call
        logic lcall;               // Call request pulse
        logic [15:0] vector;       // Target of forced call
        logic [3:0] ack_src;       // Source last acknowledged
        logic [1:0] ack_level;     // Level last acknowledged
        logic wb_ack;              // Bus acknowledge
        logic [31:0] wb_dat;       // Bus read data
    } ctrl_state_t;

    ctrl_state_t st_q;   // Registered state
    ctrl_state_t st_d;   // Next state

    logic [NUM_SRC-1:0] raw_req;   // Flags in polling order
    logic [NUM_SRC-1:0] enables;   // Enables in polling order
    logic poll_found;              // A sampled request exists
    logic [3:0] poll_idx;          // Winner index
    logic [1:0] poll_level;        // Winner level
    logic access;                  // New bus cycle this clock
    logic wr_en;                   // Register write this clock
    logic [7:0] wbyte;             // Written byte
    logic [7:0] rbyte;             // Read byte
    logic blocked;                 // Instruction forbids acknowledge
    logic prio_ok;                 // Winner outranks service level
    logic take;                    // Acknowledge fires

    // Flags arranged in polling order
    always_comb
    begin
        raw_req = '0;
        raw_req[SRC_EXT0] = st_q.tev[BIT_EXT0_FLAG];
        raw_req[SRC_SERIAL1] = serial1_flag;
        raw_req[SRC_TIMER0] = st_q.tev[BIT_TIMER0_FLAG];
        raw_req[SRC_EXT2] = st_q.xflags[0];
        raw_req[SRC_EXT1] = st_q.tev[BIT_EXT1_FLAG];
        raw_req[SRC_EXT3] = st_q.xflags[1];
        raw_req[SRC_TIMER1] = st_q.tev[BIT_TIMER1_FLAG];
        raw_req[SRC_EXT4] = st_q.xflags[2];
        raw_req[SRC_SERIAL0] = serial0_flag;
        raw_req[SRC_EXT5] = st_q.xflags[3];
        raw_req[SRC_EXT6] = st_q.xflags[4];
    end

    // Per-source enables; bit 6 of A and B left out on purpose
    always_comb
    begin
        enables = '0;
        enables[SRC_EXT0] = st_q.en_a[BIT_EXT0_EN];
        enables[SRC_TIMER0] = st_q.en_a[BIT_TIMER0_EN];
        enables[SRC_EXT1] = st_q.en_a[BIT_EXT1_EN];
        enables[SRC_TIMER1] = st_q.en_a[BIT_TIMER1_EN];
        enables[SRC_SERIAL0] = st_q.en_a[BIT_SERIAL0_EN];
        enables[SRC_SERIAL1] = st_q.en_c[BIT_SERIAL1_EN];
        enables[SRC_EXT2] = st_q.en_b[BIT_EXT2_EN];
        enables[SRC_EXT3] = st_q.en_b[BIT_EXT2_EN + 1];
        enables[SRC_EXT4] = st_q.en_b[BIT_EXT2_EN + 2];
        enables[SRC_EXT5] = st_q.en_b[BIT_EXT2_EN + 3];
        enables[SRC_EXT6] = st_q.en_b[BIT_EXT2_EN + 4];
    end

    // Priority poll over the samples; enables masked again so a late clear blocks
    irq_poll_resolver u_resolver (
        .req(st_q.sample & enables & {NUM_SRC{st_q.en_a[BIT_GLOBAL_EN]}}),
        .prio_lo(st_q.pri_lo),
        .prio_hi(st_q.pri_hi),
        .found(poll_found),
        .win_idx(poll_idx),
        .win_level(poll_level)
    );

    // Bus decode and read mux
    always_comb
    begin
        access = wb_cyc_i && wb_stb_i && !st_q.wb_ack;
        wr_en = access && wb_we_i && wb_sel_i[0];
        wbyte = wb_dat_i[7:0];
        unique case (wb_adr_i)
            OFS_ENABLE_A: rbyte = st_q.en_a;
            OFS_ENABLE_B: rbyte = st_q.en_b;
            OFS_ENABLE_C: rbyte = st_q.en_c;
            OFS_PRIO_LOW: rbyte = {1'b0, watchdog_started_status, st_q.pri_lo};
            OFS_PRIO_HIGH: rbyte = {2'b00, st_q.pri_hi};
            OFS_TIMER_EVT: rbyte = st_q.tev;
            OFS_EXTRA_FLAGS: rbyte = {2'b00, st_q.xflags, 1'b0};
            OFS_STATUS: rbyte = {3'b000, st_q.state == ST_CALL, st_q.active};
            default: rbyte = 8'h00;    // Unmapped reads as zero
        endcase
    end

    // Acknowledge decision at an instruction boundary
    always_comb
    begin
        blocked = instr_is_reti || instr_wr_irq_regs;
        prio_ok = (st_q.active == 4'h0) || (poll_level > top_level(st_q.active));
        take = mc_tick && instr_end && (st_q.state == ST_IDLE) && poll_found
            && !blocked && prio_ok;
    end

    // Next-state logic
    always_comb
    begin
        st_d = st_q;
        st_d.lcall = 1'b0;
        st_d.wb_ack = 1'b0;
        // Bus slave: one-cycle answer, unmapped writes ignored
        if (access)
        begin
            st_d.wb_ack = 1'b1;
            st_d.wb_dat = {24'h000000, rbyte};
        end
        if (wr_en)
        begin
            unique case (wb_adr_i)
                OFS_ENABLE_A: st_d.en_a = wbyte;
                OFS_ENABLE_B: st_d.en_b = wbyte;
                OFS_ENABLE_C: st_d.en_c = wbyte;
                OFS_PRIO_LOW: st_d.pri_lo = wbyte[5:0];   // Watchdog bit not stored
                OFS_PRIO_HIGH: st_d.pri_hi = wbyte[5:0];
                OFS_TIMER_EVT: st_d.tev = wbyte;
                OFS_EXTRA_FLAGS: st_d.xflags = wbyte[5:1];
                default: st_d = st_d;
            endcase
        end
        // Hardware clears the serviced flag; requests 6 and serial stay
        if (take)
        begin
            unique case (poll_idx)
                SRC_TIMER0: st_d.tev[BIT_TIMER0_FLAG] = 1'b0;
                SRC_TIMER1: st_d.tev[BIT_TIMER1_FLAG] = 1'b0;
                SRC_EXT0: st_d.tev[BIT_EXT0_FLAG] = 1'b0;
                SRC_EXT1: st_d.tev[BIT_EXT1_FLAG] = 1'b0;
                SRC_EXT2: st_d.xflags[0] = 1'b0;
                SRC_EXT3: st_d.xflags[1] = 1'b0;
                SRC_EXT4: st_d.xflags[2] = 1'b0;
                SRC_EXT5: st_d.xflags[3] = 1'b0;
                default: st_d.xflags = st_d.xflags;
            endcase
        end
        // Hardware sets win over any clear, enabled or not
        if (timer0_overflow)
        begin
            st_d.tev[BIT_TIMER0_FLAG] = 1'b1;
        end
        if (timer1_overflow)
        begin
            st_d.tev[BIT_TIMER1_FLAG] = 1'b1;
        end
        // Request 0/1: type 1 is falling edge, type 0 low level
        if (st_q.tev[BIT_EXT0_TYPE] ? (st_q.ext0_prev && !ext_req0_n) : !ext_req0_n)
        begin
            st_d.tev[BIT_EXT0_FLAG] = 1'b1;
        end
        if (st_q.tev[BIT_EXT1_TYPE] ? (st_q.ext1_prev && !ext_req1_n) : !ext_req1_n)
        begin
            st_d.tev[BIT_EXT1_FLAG] = 1'b1;
        end
        st_d.xflags = st_d.xflags | ext_edge;
        st_d.ext0_prev = ext_req0_n;
        st_d.ext1_prev = ext_req1_n;
        // Sample once per machine cycle, gated by enables and global bit
        if (mc_tick)
        begin
            st_d.sample = raw_req & enables & {NUM_SRC{st_q.en_a[BIT_GLOBAL_EN]}};
        end
        // Return drops the highest level in service
        if (reti_done && (st_q.active != 4'h0))
        begin
            st_d.active[top_level(st_q.active)] = 1'b0;
        end
        // Forced call sequencing
        unique case (st_q.state)
            ST_IDLE:
            begin
                if (take)
                begin
                    st_d.state = ST_CALL;
                    st_d.call_cnt = 3'(CALL_MC - 1);
                    st_d.lcall = 1'b1;
                    st_d.vector = SRC_VECTOR[poll_idx];
                    st_d.ack_src = poll_idx;
                    st_d.ack_level = poll_level;
                    st_d.active[poll_level] = 1'b1;
                end
            end
            ST_CALL:
            begin
                if (mc_tick)
                begin
                    if (st_q.call_cnt == 3'h0)
                    begin
                        st_d.state = ST_IDLE;
                    end
                    else
                    begin
                        st_d.call_cnt = st_q.call_cnt - 3'h1;
                    end
                end
            end
        endcase
    end

    // State register with clock enable and synchronous reset
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            st_q <= '{en_a: RST_ENABLE, en_b: RST_ENABLE, en_c: RST_ENABLE,
                      pri_lo: RST_PRIO, pri_hi: RST_PRIO, tev: RST_TIMER_EVT,
                      xflags: RST_EXTRA_FLAGS, ext0_prev: 1'b1, ext1_prev: 1'b1,
                      sample: '0, active: 4'h0, state: ST_IDLE, call_cnt: 3'h0,
                      lcall: 1'b0, vector: 16'h0000, ack_src: 4'h0, ack_level: 2'h0,
                      wb_ack: 1'b0, wb_dat: 32'h00000000};
        end
        else if (ce)
        begin
            st_q <= st_d;
        end
    end

    // Outputs straight from the state register
    assign wb_dat_o = st_q.wb_dat;
    assign wb_ack_o = st_q.wb_ack;
    assign lcall_req = st_q.lcall;
    assign lcall_vector = st_q.vector;
    assign lcall_busy = st_q.state == ST_CALL;
    assign timer0_run = st_q.tev[BIT_TIMER0_RUN];   // Timer only
    assign timer1_run = st_q.tev[BIT_TIMER1_RUN];

    // Checks on the controller behaviour
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_global_gate: assert property ($rose(st_q.lcall) |-> $past(st_q.en_a[BIT_GLOBAL_EN]))
        else $error("call taken while global enable was low");

    a_enable_gate: assert property ($rose(st_q.lcall) |-> $past(enables[poll_idx]))
        else $error("call taken for a disabled source");

    a_blocked_instr: assert property ((ce && instr_end && blocked) |=> !st_q.lcall)
        else $error("call taken during return or enable write");

    a_prio_preempt: assert property
        ($rose(st_q.lcall) && ($past(st_q.active) != 4'h0)
         |-> st_q.ack_level > top_level($past(st_q.active)))
        else $error("call did not outrank the level in service");

    a_call_length: assert property (st_q.lcall |-> lcall_busy [*6])
        else $error("forced call shorter than six cycles");

    a_sample_hold: assert property (!(ce && mc_tick) |=> $stable(st_q.sample))
        else $error("sample changed outside a machine cycle");

    a_timer_set: assert property ((ce && timer1_overflow) |=> st_q.tev[BIT_TIMER1_FLAG])
        else $error("timer 1 flag not set on overflow");

    a_timer_clear: assert property
        ((ce && take && poll_idx == SRC_TIMER0 && !timer0_overflow)
         |=> !st_q.tev[BIT_TIMER0_FLAG])
        else $error("timer 0 flag not cleared on service");

    a_reti_level: assert property
        ((ce && reti_done && st_q.active != 4'h0 && !take)
         |=> st_q.active[$past(top_level(st_q.active))] == 1'b0)
        else $error("return did not end the service level");

    a_vector_out: assert property
        ($rose(st_q.lcall) |-> lcall_vector == SRC_VECTOR[st_q.ack_src])
        else $error("vector does not match acknowledged source");

    a_edge_flag: assert property
        ((ce && st_q.tev[BIT_EXT0_TYPE] && st_q.ext0_prev && !ext_req0_n)
         |=> st_q.tev[BIT_EXT0_FLAG])
        else $error("falling edge on request 0 missed");

    c_call_taken: cover property ($rose(st_q.lcall));
    c_nested_call: cover property ($rose(st_q.lcall) && $past(st_q.active) != 4'h0);
    c_reti_seen: cover property (ce && reti_done && st_q.active != 4'h0);
    c_bus_write: cover property (ce && wr_en);

endmodule

// ---- src/irq_ctrl_pkg.sv ----
// Shared constants for the processor interrupt controller
package irq_ctrl_pkg;

    // Source count, level count and group count
    localparam int NUM_SRC = 11;
    localparam int NUM_LEVELS = 4;
    localparam int NUM_GROUPS = 6;

    // Register byte offsets on the bus
    localparam logic [7:0] OFS_ENABLE_A = 8'h00;
    localparam logic [7:0] OFS_ENABLE_B = 8'h04;
    localparam logic [7:0] OFS_ENABLE_C = 8'h08;
    localparam logic [7:0] OFS_PRIO_LOW = 8'h0c;
    localparam logic [7:0] OFS_PRIO_HIGH = 8'h10;
    localparam logic [7:0] OFS_TIMER_EVT = 8'h14;
    localparam logic [7:0] OFS_EXTRA_FLAGS = 8'h18;
    localparam logic [7:0] OFS_STATUS = 8'h1c;

    // Reset values
    localparam logic [7:0] RST_ENABLE = 8'h00;
    localparam logic [5:0] RST_PRIO = 6'h00;
    localparam logic [7:0] RST_TIMER_EVT = 8'h00;
    localparam logic [4:0] RST_EXTRA_FLAGS = 5'h00;

    // Enable register field positions
    localparam int BIT_GLOBAL_EN = 7;
    localparam int BIT_SERIAL0_EN = 4;
    localparam int BIT_TIMER1_EN = 3;
    localparam int BIT_EXT1_EN = 2;
    localparam int BIT_TIMER0_EN = 1;
    localparam int BIT_EXT0_EN = 0;
    localparam int BIT_EXT2_EN = 1;
    localparam int BIT_SERIAL1_EN = 0;

    // Timer event control field positions
    localparam int BIT_TIMER1_FLAG = 7;
    localparam int BIT_TIMER1_RUN = 6;
    localparam int BIT_TIMER0_FLAG = 5;
    localparam int BIT_TIMER0_RUN = 4;
    localparam int BIT_EXT1_FLAG = 3;
    localparam int BIT_EXT1_TYPE = 2;
    localparam int BIT_EXT0_FLAG = 1;
    localparam int BIT_EXT0_TYPE = 0;

    // Extra flags sit at bits 5..1, watchdog status at bit 6 of priority low
    localparam int BIT_EXTRA_LSB = 1;
    localparam int BIT_WDOG_STATUS = 6;

    // Source indices in polling order (first wins within a level)
    localparam logic [3:0] SRC_EXT0 = 4'h0;
    localparam logic [3:0] SRC_SERIAL1 = 4'h1;
    localparam logic [3:0] SRC_TIMER0 = 4'h2;
    localparam logic [3:0] SRC_EXT2 = 4'h3;
    localparam logic [3:0] SRC_EXT1 = 4'h4;
    localparam logic [3:0] SRC_EXT3 = 4'h5;
    localparam logic [3:0] SRC_TIMER1 = 4'h6;
    localparam logic [3:0] SRC_EXT4 = 4'h7;
    localparam logic [3:0] SRC_SERIAL0 = 4'h8;
    localparam logic [3:0] SRC_EXT5 = 4'h9;
    localparam logic [3:0] SRC_EXT6 = 4'ha;

    // Timing in machine cycles
    localparam int DETECT_MC = 1;
    localparam int CALL_MC = 6;
    localparam int MIN_LATENCY_MC = DETECT_MC + CALL_MC;

    // Controller sequencing states
    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_CALL = 1'b1
    } call_state_t;

    // Priority group of a source
    function automatic logic [2:0] src_group(input logic [3:0] idx);
        logic [2:0] g;
        g = 3'(idx >> 1);
        return g;
    endfunction

    // Level of a source from the two priority registers
    function automatic logic [1:0] src_level(input logic [3:0] idx, input logic [5:0] lo,
                                             input logic [5:0] hi);
        logic [2:0] g;
        g = src_group(idx);
        return {hi[g], lo[g]};
    endfunction

    // Highest level now in service, valid only when any bit is set
    function automatic logic [1:0] top_level(input logic [3:0] act);
        logic [1:0] t;
        t = 2'h0;
        for (int i = 0; i < NUM_LEVELS; i++)
        begin
            if (act[i])
            begin
                t = 2'(i);
            end
        end
        return t;
    endfunction

endpackage

// ---- src/irq_poll_resolver.sv ----
`timescale 1ns/1ps
// Picks the winning request: highest level first, then polling order
module irq_poll_resolver
    import irq_ctrl_pkg::*;
(
    input wire logic [NUM_SRC-1:0] req,
    input wire logic [5:0] prio_lo,
    input wire logic [5:0] prio_hi,
    output logic found,
    output logic [3:0] win_idx,
    output logic [1:0] win_level
);

    // Scan levels from 3 down, sources in polling order
    always_comb
    begin
        found = 1'b0;
        win_idx = 4'h0;
        win_level = 2'h0;
        for (int lvl = NUM_LEVELS - 1; lvl >= 0; lvl--)
        begin
            for (int i = 0; i < NUM_SRC; i++)
            begin
                if (!found && req[i] && (src_level(4'(i), prio_lo, prio_hi) == 2'(lvl)))
                begin
                    found = 1'b1;
                    win_idx = 4'(i);
                    win_level = 2'(lvl);
                end
            end
        end
    end

endmodule

// ---- test/core_seq_model.sv ----
`timescale 1ns/1ps
// Core stand-in: one machine cycle per clock, ends an instruction each cycle outside a forced call
module core_seq_model
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic lcall_busy,
    input wire logic blk_wr,
    input wire logic reti_go,
    output logic mc_tick,
    output logic instr_end,
    output logic instr_is_reti,
    output logic instr_wr_irq_regs,
    output logic reti_done
);
    // Forced call owns the core, so no instruction ends while it runs
    always @(posedge clk)
    begin
        mc_tick <= rst_n;
        instr_end <= rst_n && !lcall_busy;
        instr_is_reti <= reti_go;
        instr_wr_irq_regs <= blk_wr;
        reti_done <= reti_go;
    end
endmodule

// ---- test/irq_ctrl_tb_top.sv ----
`timescale 1ns/1ps
// Bus and source stimulus, scoreboard on reads and forced calls
module irq_ctrl_tb_top
    import irq_ctrl_pkg::*;
;
    // Clock, reset, bus master
    logic clk = 1'b0, rst_n = 1'b0, ce = 1'b1;
    logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    // Core side, sources and call outputs
    logic mc_tick, instr_end, instr_is_reti, instr_wr_irq_regs, reti_done;
    logic timer0_overflow = 1'b0, timer1_overflow = 1'b0;
    logic ext_req0_n = 1'b1, ext_req1_n = 1'b1;
    logic [4:0] ext_edge = 5'h00;
    logic serial0_flag = 1'b0, serial1_flag = 1'b0;
    logic watchdog_started_status = 1'b0;
    logic lcall_req, lcall_busy;
    logic timer0_run, timer1_run;
    logic [15:0] lcall_vector;
    logic blk_wr = 1'b0, reti_go = 1'b0;
    // Scoreboard: notes hold read data, or latency and vector of a call
    int cyc_n = 0, t0 = 0, err_total = 0, n_compared = 0;
    int seed = 32'hd61dec54;
    logic [31:0] rd_q[$];
    logic [23:0] call_q[$];
    logic [23:0] e;
    logic [7:0] d;
    // Sources whose pulse path has a fixed answer time
    logic [10:0] exact_lat = 11'b110_1110_1100;

    irq_ctrl dut
    (
        .clk, .rst_n, .ce, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
        .wb_dat_i, .wb_dat_o, .wb_ack_o, .mc_tick, .instr_end, .instr_is_reti,
        .instr_wr_irq_regs, .reti_done, .timer0_overflow, .timer1_overflow,
        .ext_req0_n, .ext_req1_n, .ext_edge, .serial0_flag, .serial1_flag,
        .watchdog_started_status, .lcall_req, .lcall_vector, .lcall_busy,
        .timer0_run, .timer1_run
    );
    core_seq_model core
    (
        .clk, .rst_n, .lcall_busy, .blk_wr, .reti_go, .mc_tick, .instr_end,
        .instr_is_reti, .instr_wr_irq_regs, .reti_done
    );

    // 20 MHz clock
    always #25 clk = ~clk;

    // Count, compare, report
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            err_total++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Counts, verdict, stop
    task automatic end_of_test();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // One classic cycle; for a read, dv is the expected byte
    task automatic wb(input logic we, input logic [7:0] a, input logic [7:0] dv);
        @(posedge clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_sel_i <= 4'hf;
        wb_dat_i <= {24'h0, dv};
        if (!we)
            rd_q.push_back({24'h0, dv});
        do
            @(posedge clk);
        while (wb_ack_o !== 1'b1);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask

    // Note a call of source s; latency ff means not timed
    task automatic expv(input int s, input logic [7:0] lat);
        call_q.push_back({lat, 16'h00b0 + 16'(s * 16)});
    endtask

    // Raise one source; pulses and pin falls last one cycle
    task automatic fire(input int s);
        @(posedge clk);
        t0 = cyc_n;
        case (s)
            0: ext_req0_n <= 1'b0;
            1: serial1_flag <= 1'b1;
            2: timer0_overflow <= 1'b1;
            4: ext_req1_n <= 1'b0;
            6: timer1_overflow <= 1'b1;
            8: serial0_flag <= 1'b1;
            default: ext_edge[s == 10 ? 4 : (s - 3) / 2] <= 1'b1;
        endcase
        @(posedge clk);
        {timer0_overflow, timer1_overflow, ext_req0_n, ext_req1_n} <= 4'h3;
        ext_edge <= 5'h00;
    endtask

    // Let the call run out, then return from the handler
    task automatic ret();
        repeat (12) @(posedge clk);
        chk({31'h0, lcall_busy}, 32'h0);
        reti_go <= 1'b1;
        @(posedge clk);
        reti_go <= 1'b0;
    endtask

    // Software-cleared flags dropped before the return
    task automatic done();
        repeat (12) @(posedge clk);
        {serial0_flag, serial1_flag} <= 2'b00;
        wb(1'b1, OFS_EXTRA_FLAGS, 8'h00);
        ret();
    endtask

    // Scoreboard and hang guard
    always @(posedge clk)
    begin
        cyc_n <= cyc_n + 1;
        if (cyc_n == 20000)
        begin
            err_total++;
            end_of_test();
        end
        if (wb_ack_o && !wb_we_i)
            chk(wb_dat_o, rd_q.pop_front());
        if (lcall_req)
        begin
            e = call_q.size() > 0 ? call_q.pop_front() : 24'hffffff;
            if (e[23:16] != 8'hff)
                chk(32'(cyc_n - t0), {24'h0, e[23:16]});
            chk({16'h0, lcall_vector}, {16'h0, e[15:0]});
        end
    end

    // Main sequence
    initial
    begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        // Reset values, unmapped word last
        for (int a = 0; a <= 32; a += 4)
            wb(1'b0, 8'(a), 8'h00);
        d = 8'($random(seed)) & 8'h3e;
        wb(1'b1, OFS_ENABLE_B, d);
        wb(1'b0, OFS_ENABLE_B, d);
        d = 8'($random(seed));
        wb(1'b1, OFS_PRIO_HIGH, d);
        wb(1'b0, OFS_PRIO_HIGH, d & 8'h3f);
        // Status bit visible; level type raises the flag while the pin is low
        watchdog_started_status <= 1'b1;
        ext_req0_n <= 1'b0;
        wb(1'b0, OFS_PRIO_LOW, 8'h40);
        watchdog_started_status <= 1'b0;
        wb(1'b0, OFS_TIMER_EVT, 8'h02);
        wb(1'b1, OFS_TIMER_EVT, 8'h01);
        wb(1'b1, OFS_TIMER_EVT, 8'h01);
        wb(1'b0, OFS_TIMER_EVT, 8'h01);
        ext_req0_n <= 1'b1;
        // Run bits reach the timers and nothing else
        wb(1'b1, OFS_TIMER_EVT, 8'h51);
        chk({30'h0, timer1_run, timer0_run}, 32'h3);
        wb(1'b1, OFS_TIMER_EVT, 8'h05);
        chk({30'h0, timer1_run, timer0_run}, 32'h0);
        // Global gate off: flag set, no call until the gate opens
        wb(1'b1, OFS_ENABLE_A, 8'h1f);
        wb(1'b1, OFS_ENABLE_B, 8'h3e);
        wb(1'b1, OFS_ENABLE_C, 8'h01);
        wb(1'b1, OFS_PRIO_HIGH, 8'h00);
        // Clock enable low freezes state: this timer 1 pulse is lost
        ce <= 1'b0;
        fire(6);
        ce <= 1'b1;
        fire(2);
        wb(1'b0, OFS_TIMER_EVT, 8'h25);
        expv(2, 8'hff);
        wb(1'b1, OFS_ENABLE_A, 8'h9f);
        done();
        wb(1'b0, OFS_TIMER_EVT, 8'h05);
        // Every source reaches its own vector
        for (int s = 0; s < NUM_SRC; s++)
        begin
            expv(s, exact_lat[s] ? 8'h04 : 8'hff);
            fire(s);
            done();
        end
        // Gating-register write in progress holds the call back
        blk_wr <= 1'b1;
        fire(6);
        repeat (8) @(posedge clk);
        expv(6, 8'hff);
        blk_wr <= 1'b0;
        ret();
        // Levels: timer 0 and ext 2 at 1, ext 1 and ext 3 at 2
        wb(1'b1, OFS_PRIO_LOW, 8'h02);
        wb(1'b1, OFS_PRIO_HIGH, 8'h04);
        expv(3, 8'h04);
        fire(3);
        repeat (12) @(posedge clk);
        fire(9);
        fire(2);
        repeat (12) @(posedge clk);
        expv(5, 8'h04);
        fire(5);
        expv(2, 8'hff);
        expv(9, 8'hff);
        repeat (4) ret();
        repeat (12) @(posedge clk);
        chk(32'(call_q.size() + rd_q.size()), 32'h0);
        end_of_test();
    end
endmodule
